// ===== verilog/amp_analyzer.sv
// Analyzer tail: flow sampling, mirroring, monitoring and policer pool mapping
`timescale 1ns/10ps
module amp_analyzer
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire amp_pkg::amp_reg_req_type reg_req,
  output logic [amp_pkg::DATA_W-1:0] reg_rdata,
  input wire amp_pkg::amp_frame_in_type frame_in,
  output amp_pkg::amp_frame_out_type frame_out,
  input wire logic tx_valid,
  input wire logic [amp_pkg::PORT_W-1:0] tx_port,
  output logic tx_sample,
  input wire logic move_valid,
  input wire logic [amp_pkg::PORT_W-1:0] move_port,
  input wire logic [amp_pkg::NUM_EVENTS-1:0] event_in,
  input wire logic learn_fail
);

  // Address falls inside a replicated register window
  function automatic logic in_window(input logic [amp_pkg::ADDR_W-1:0] a, input logic [amp_pkg::ADDR_W-1:0] base);
    in_window = (a >= base) && (a < base + amp_pkg::ADDR_W'(amp_pkg::NUM_PORTS));
  endfunction

  // Physical port number is in range
  function automatic logic port_ok(input logic [amp_pkg::PORT_W-1:0] p);
    port_ok = (p < amp_pkg::PORT_W'(amp_pkg::NUM_PORTS));
  endfunction

  // Random draw below the programmed probability
  function automatic logic draw_hit(input logic [amp_pkg::PROB_W-1:0] rnd, input logic [amp_pkg::PROB_W-1:0] prob);
    draw_hit = (rnd < prob);
  endfunction

  logic [amp_pkg::SMP_CFG_W-1:0] smp_cfg_ff [amp_pkg::NUM_PORTS];
  logic [amp_pkg::PORT_POLICER_ENABLES_W-1:0] port_policer_enables_ff [amp_pkg::NUM_PORTS];
  logic cpu_mirror_enable_ff;
  logic cpu_self_kill_enable_ff;
  logic [amp_pkg::NUM_PORTS-1:0] learn_mirror_mask_ff;
  logic [amp_pkg::NUM_PORTS-1:0] egress_mirror_mask_ff;
  logic [amp_pkg::NUM_PORTS-1:0] mirror_port_mask_ff;
  logic [amp_pkg::NUM_PORTS-1:0] ingress_mirror_enable_ff;
  logic [amp_pkg::QUEUE_W-1:0] sampling_cpu_queue_ff;
  logic [amp_pkg::QUEUE_W-1:0] mirror_cpu_queue_ff;
  logic [amp_pkg::VID_W-1:0] vlan_index_ff;
  logic vid_mirror_flag_ff [amp_pkg::NUM_VID];
  logic [amp_pkg::NUM_PORTS-1:0] port_move_status_ff;
  logic [amp_pkg::NUM_EVENTS-1:0] sticky_event_flags_ff;
  logic [amp_pkg::CNT_W-1:0] learn_discard_counter_ff;
  logic [amp_pkg::LFSR_W-1:0] lfsr_ff;
  logic [amp_pkg::DATA_W-1:0] rdata_ff;
  amp_pkg::amp_frame_out_type frame_out_ff;
  logic tx_sample_ff;

  logic wr_sampler;
  logic wr_pol;
  logic [amp_pkg::PORT_W-1:0] wr_idx;
  logic [amp_pkg::DATA_W-1:0] nxt_rdata;
  amp_pkg::amp_frame_out_type nxt_frame_out;
  logic nxt_tx_sample;

  assign wr_idx = reg_req.addr[amp_pkg::PORT_W-1:0];
  assign wr_sampler = reg_req.wr && in_window(reg_req.addr, amp_pkg::OFS_SAMPLER);
  assign wr_pol = reg_req.wr && in_window(reg_req.addr, amp_pkg::OFS_PORT_POLICER_ENABLES);

  // Per-port sampler and policer configuration; nothing allocated after reset
  always_ff @(posedge clk_sys)
  begin
    for (int i = 0; i < amp_pkg::NUM_PORTS; i++)
    begin
      if (!reset_n)
      begin
        smp_cfg_ff[i] <= amp_pkg::CFG_RESET[amp_pkg::SMP_CFG_W-1:0];
        port_policer_enables_ff[i] <= amp_pkg::CFG_RESET[amp_pkg::PORT_POLICER_ENABLES_W-1:0];
      end
      else
      begin
        if (wr_sampler && (wr_idx == amp_pkg::PORT_W'(i)))
          smp_cfg_ff[i] <= reg_req.wdata[amp_pkg::SMP_CFG_W-1:0];
        if (wr_pol && (wr_idx == amp_pkg::PORT_W'(i)))
          port_policer_enables_ff[i] <= reg_req.wdata[amp_pkg::PORT_POLICER_ENABLES_W-1:0];
      end
    end
  end

  // Global mirror and queue configuration
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      cpu_mirror_enable_ff <= 1'b0;
      cpu_self_kill_enable_ff <= 1'b0;
      learn_mirror_mask_ff <= amp_pkg::CFG_RESET[amp_pkg::NUM_PORTS-1:0];
      egress_mirror_mask_ff <= amp_pkg::CFG_RESET[amp_pkg::NUM_PORTS-1:0];
      mirror_port_mask_ff <= amp_pkg::CFG_RESET[amp_pkg::NUM_PORTS-1:0];
      ingress_mirror_enable_ff <= amp_pkg::CFG_RESET[amp_pkg::NUM_PORTS-1:0];
      sampling_cpu_queue_ff <= amp_pkg::CFG_RESET[amp_pkg::QUEUE_W-1:0];
      mirror_cpu_queue_ff <= amp_pkg::CFG_RESET[amp_pkg::QUEUE_W-1:0];
      vlan_index_ff <= amp_pkg::CFG_RESET[amp_pkg::VID_W-1:0];
    end
    else if (reg_req.wr)
    begin
      case (reg_req.addr)
        amp_pkg::OFS_MIRROR_CTRL:
        begin
          cpu_mirror_enable_ff <= reg_req.wdata[amp_pkg::CTRL_CPU_MIRROR_BIT];
          cpu_self_kill_enable_ff <= reg_req.wdata[amp_pkg::CTRL_KILL_BIT];
        end
        amp_pkg::OFS_LEARN_MIRROR: learn_mirror_mask_ff <= reg_req.wdata[amp_pkg::NUM_PORTS-1:0];
        amp_pkg::OFS_EGRESS_MIRROR: egress_mirror_mask_ff <= reg_req.wdata[amp_pkg::NUM_PORTS-1:0];
        amp_pkg::OFS_MIRROR_PORTS: mirror_port_mask_ff <= reg_req.wdata[amp_pkg::NUM_PORTS-1:0];
        amp_pkg::OFS_INGRESS_MIRROR: ingress_mirror_enable_ff <= reg_req.wdata[amp_pkg::NUM_PORTS-1:0];
        amp_pkg::OFS_CPU_QUEUES:
        begin
          sampling_cpu_queue_ff <= reg_req.wdata[amp_pkg::CPU_QUEUE_SET_SAMPLE_LSB +: amp_pkg::QUEUE_W];
          mirror_cpu_queue_ff <= reg_req.wdata[amp_pkg::MIRROR_CPU_QUEUE_LSB +: amp_pkg::QUEUE_W];
        end
        amp_pkg::OFS_VLAN_INDEX: vlan_index_ff <= reg_req.wdata[amp_pkg::VID_W-1:0];
        default: ;
      endcase
    end
  end

  // Vid_mirror_flag flag table, written through the index register
  always_ff @(posedge clk_sys)
  begin
    if (reg_req.wr && (reg_req.addr == amp_pkg::OFS_VID_MIRROR_FLAG))
      vid_mirror_flag_ff[vlan_index_ff] <= reg_req.wdata[0];
  end

  // Port move status: set wins over write-one-to-clear
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      port_move_status_ff <= amp_pkg::CFG_RESET[amp_pkg::NUM_PORTS-1:0];
    else
    begin
      for (int i = 0; i < amp_pkg::NUM_PORTS; i++)
      begin
        if (move_valid && (move_port == amp_pkg::PORT_W'(i)))
          port_move_status_ff[i] <= 1'b1;
        else if (reg_req.wr && (reg_req.addr == amp_pkg::OFS_PORT_MOVE) && reg_req.wdata[i])
          port_move_status_ff[i] <= 1'b0;
      end
    end
  end

  // Sticky analyzer events: set wins over write-one-to-clear
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      sticky_event_flags_ff <= amp_pkg::CFG_RESET[amp_pkg::NUM_EVENTS-1:0];
    else if (reg_req.wr && (reg_req.addr == amp_pkg::OFS_EVENTS))
      sticky_event_flags_ff <= (sticky_event_flags_ff & ~reg_req.wdata[amp_pkg::NUM_EVENTS-1:0]) | event_in;
    else
      sticky_event_flags_ff <= sticky_event_flags_ff | event_in;
  end

  // Learn discard counter; a write clears it, a coincident failure counts as one
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      learn_discard_counter_ff <= amp_pkg::CFG_RESET;
    else if (reg_req.wr && (reg_req.addr == amp_pkg::OFS_LEARN_DISCARD))
      learn_discard_counter_ff <= amp_pkg::CNT_W'(learn_fail);
    else if (learn_fail)
      learn_discard_counter_ff <= learn_discard_counter_ff + 1'b1;
  end

  // Free-running Galois LFSR for the samplers
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      lfsr_ff <= amp_pkg::LFSR_SEED;
    else if (lfsr_ff[0])
      lfsr_ff <= (lfsr_ff >> 1) ^ amp_pkg::LFSR_TAPS;
    else
      lfsr_ff <= lfsr_ff >> 1;
  end

  // Register read mux; data valid only in the cycle after the read strobe
  always_comb
  begin
    nxt_rdata = '0;
    if (reg_req.rd)
    begin
      if (in_window(reg_req.addr, amp_pkg::OFS_SAMPLER))
        nxt_rdata = amp_pkg::DATA_W'(smp_cfg_ff[reg_req.addr[amp_pkg::PORT_W-1:0]]);
      else if (in_window(reg_req.addr, amp_pkg::OFS_PORT_POLICER_ENABLES))
        nxt_rdata = amp_pkg::DATA_W'(port_policer_enables_ff[reg_req.addr[amp_pkg::PORT_W-1:0]]);
      else
      begin
        case (reg_req.addr)
          amp_pkg::OFS_MIRROR_CTRL:
          begin
            nxt_rdata[amp_pkg::CTRL_CPU_MIRROR_BIT] = cpu_mirror_enable_ff;
            nxt_rdata[amp_pkg::CTRL_KILL_BIT] = cpu_self_kill_enable_ff;
          end
          amp_pkg::OFS_LEARN_MIRROR: nxt_rdata = amp_pkg::DATA_W'(learn_mirror_mask_ff);
          amp_pkg::OFS_EGRESS_MIRROR: nxt_rdata = amp_pkg::DATA_W'(egress_mirror_mask_ff);
          amp_pkg::OFS_MIRROR_PORTS: nxt_rdata = amp_pkg::DATA_W'(mirror_port_mask_ff);
          amp_pkg::OFS_INGRESS_MIRROR: nxt_rdata = amp_pkg::DATA_W'(ingress_mirror_enable_ff);
          amp_pkg::OFS_CPU_QUEUES:
          begin
            nxt_rdata[amp_pkg::CPU_QUEUE_SET_SAMPLE_LSB +: amp_pkg::QUEUE_W] = sampling_cpu_queue_ff;
            nxt_rdata[amp_pkg::MIRROR_CPU_QUEUE_LSB +: amp_pkg::QUEUE_W] = mirror_cpu_queue_ff;
          end
          amp_pkg::OFS_VLAN_INDEX: nxt_rdata = amp_pkg::DATA_W'(vlan_index_ff);
          amp_pkg::OFS_VID_MIRROR_FLAG: nxt_rdata = amp_pkg::DATA_W'(vid_mirror_flag_ff[vlan_index_ff]);
          amp_pkg::OFS_PORT_MOVE: nxt_rdata = amp_pkg::DATA_W'(port_move_status_ff);
          amp_pkg::OFS_EVENTS: nxt_rdata = amp_pkg::DATA_W'(sticky_event_flags_ff);
          amp_pkg::OFS_LEARN_DISCARD: nxt_rdata = learn_discard_counter_ff;
          default: nxt_rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      rdata_ff <= '0;
    else
      rdata_ff <= nxt_rdata;
  end

  // Frame decision: sampling, mirror probes, mask updates and policer mapping
  logic src_ok;
  logic [amp_pkg::SMP_CFG_W-1:0] src_smp;
  logic [amp_pkg::PORT_POLICER_ENABLES_W-1:0] src_pol;
  logic probe_learn;
  logic probe_cpu;
  logic probe_ingress;
  logic probe_egress;
  logic probe_vid;
  logic probe_rule;
  logic any_probe;
  logic rx_hit;

  assign src_ok = port_ok(frame_in.src_port);
  assign src_smp = src_ok ? smp_cfg_ff[frame_in.src_port] : '0;
  assign src_pol = src_ok ? port_policer_enables_ff[frame_in.src_port] : '0;
  assign probe_learn = frame_in.learn_frame && (learn_mirror_mask_ff != '0);
  assign probe_cpu = cpu_mirror_enable_ff && frame_in.forward_port_mask[amp_pkg::CPU_PORT];
  assign probe_ingress = src_ok && ingress_mirror_enable_ff[frame_in.src_port];
  assign probe_egress = |(egress_mirror_mask_ff & frame_in.forward_port_mask);
  assign probe_vid = vid_mirror_flag_ff[frame_in.vid];
  assign probe_rule = frame_in.rule_hit && frame_in.rule_action_mirror;
  // One OR of all probes, so the mask is added once
  assign any_probe = probe_learn | probe_cpu | probe_ingress | probe_egress | probe_vid | probe_rule;
  assign rx_hit = src_smp[amp_pkg::SMP_RX_BIT]
                  && draw_hit(lfsr_ff[amp_pkg::PROB_W-1:0], src_smp[amp_pkg::PROB_W-1:0]);

  always_comb
  begin
    nxt_frame_out = '0;
    nxt_frame_out.valid = frame_in.valid;
    nxt_frame_out.forward_port_mask = frame_in.forward_port_mask;
    nxt_frame_out.cpu_queue_set = frame_in.cpu_queue_set;
    if (frame_in.valid)
    begin
      if (rx_hit)
      begin
        nxt_frame_out.sampled = 1'b1;
        nxt_frame_out.forward_port_mask[amp_pkg::CPU_PORT] = 1'b1;
        nxt_frame_out.cpu_queue_set[sampling_cpu_queue_ff] = 1'b1;
      end
      if (any_probe)
      begin
        nxt_frame_out.mirrored = 1'b1;
        nxt_frame_out.forward_port_mask = nxt_frame_out.forward_port_mask | mirror_port_mask_ff;
        if (mirror_port_mask_ff[amp_pkg::CPU_PORT])
          nxt_frame_out.cpu_queue_set[mirror_cpu_queue_ff] = 1'b1;
      end
      if (frame_in.learn_frame && frame_in.learn_enabled)
        nxt_frame_out.forward_port_mask = nxt_frame_out.forward_port_mask | learn_mirror_mask_ff;
      if (cpu_self_kill_enable_ff && (frame_in.src_port == amp_pkg::CPU_PORT))
        nxt_frame_out.forward_port_mask[amp_pkg::CPU_PORT] = 1'b0;
      // Up to three policers with the per-port order
      nxt_frame_out.pol_order = src_pol[amp_pkg::POL_ORDER_LSB +: 2];
      nxt_frame_out.port_pol_valid = src_pol[amp_pkg::POL_PORT_BIT];
      nxt_frame_out.port_pol_idx = amp_pkg::POOL_PORT_BASE + amp_pkg::POL_W'(frame_in.src_port);
      nxt_frame_out.qos_pol_valid = src_pol[amp_pkg::POL_QOS_LSB + frame_in.qos];
      nxt_frame_out.qos_pol_idx = amp_pkg::POOL_QOS_BASE
                                  + amp_pkg::POL_W'(frame_in.src_port) * amp_pkg::POOL_QOS_STRIDE
                                  + amp_pkg::POL_W'(frame_in.qos);
      nxt_frame_out.rule_pol_valid = frame_in.rule_hit && frame_in.rule_police_enable;
      nxt_frame_out.rule_pol_idx = amp_pkg::POOL_RULE_BASE + amp_pkg::POL_W'(frame_in.rule_policer_index);
    end
  end

  // Transmit-side sampling uses an independent slice of the LFSR
  always_comb
  begin
    nxt_tx_sample = 1'b0;
    if (tx_valid && port_ok(tx_port))
      nxt_tx_sample = smp_cfg_ff[tx_port][amp_pkg::SMP_TX_BIT]
                      && draw_hit(lfsr_ff[amp_pkg::LFSR_W-1 -: amp_pkg::PROB_W],
                                  smp_cfg_ff[tx_port][amp_pkg::PROB_W-1:0]);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      frame_out_ff <= '0;
      tx_sample_ff <= 1'b0;
    end
    else
    begin
      frame_out_ff <= nxt_frame_out;
      tx_sample_ff <= nxt_tx_sample;
    end
  end

  assign reg_rdata = rdata_ff;
  assign frame_out = frame_out_ff;
  assign tx_sample = tx_sample_ff;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence rx_frame_s;
    frame_in.valid && src_ok;
  endsequence

  sample_copy_a: assert property (frame_out.sampled |-> frame_out.cpu_queue_set[sampling_cpu_queue_ff])
    else $error("sampled frame lacks sampling queue");
  prob_zero_a: assert property (rx_frame_s ##0 (src_smp[amp_pkg::PROB_W-1:0] == '0) |=> !frame_out.sampled)
    else $error("sampled with zero probability");
  tx_enable_a: assert property (tx_valid && !smp_cfg_ff[tx_port][amp_pkg::SMP_TX_BIT] |=> !tx_sample)
    else $error("transmit sample while disabled");
  learn_probe_a: assert property (frame_in.valid && frame_in.learn_frame && (learn_mirror_mask_ff != '0)
                                  |=> frame_out.mirrored)
    else $error("learn mirror probe missed");
  cpu_probe_a: assert property (frame_in.valid && cpu_mirror_enable_ff
                                && frame_in.forward_port_mask[amp_pkg::CPU_PORT] |=> frame_out.mirrored)
    else $error("cpu mirror probe missed");
  ingress_probe_a: assert property (rx_frame_s ##0 ingress_mirror_enable_ff[frame_in.src_port]
                                    |=> frame_out.mirrored)
    else $error("ingress mirror probe missed");
  egress_probe_a: assert property (frame_in.valid && |(egress_mirror_mask_ff & frame_in.forward_port_mask)
                                   |=> frame_out.mirrored)
    else $error("egress mirror probe missed");
  vid_probe_a: assert property (frame_in.valid && vid_mirror_flag_ff[frame_in.vid] |=> frame_out.mirrored)
    else $error("vid_mirror_flag probe missed");
  rule_probe_a: assert property (frame_in.valid && frame_in.rule_hit && frame_in.rule_action_mirror
                                 |=> frame_out.mirrored)
    else $error("rule mirror probe missed");
  // Mask taken from the cycle the decision was made; self-kill may drop the CPU port
  mirror_mask_a: assert property (frame_out.mirrored |-> ((frame_out.forward_port_mask
                                  | (12'h001 << amp_pkg::CPU_PORT)) & $past(mirror_port_mask_ff))
                                  == $past(mirror_port_mask_ff))
    else $error("mirror ports not added");
  mirror_queue_a: assert property (frame_out.mirrored && $past(mirror_port_mask_ff[amp_pkg::CPU_PORT])
                                   |-> frame_out.cpu_queue_set[$past(mirror_cpu_queue_ff)])
    else $error("mirror queue not added");
  learn_mask_a: assert property (frame_in.valid && frame_in.learn_frame && frame_in.learn_enabled
                                 |=> ((frame_out.forward_port_mask | (12'h001 << amp_pkg::CPU_PORT))
                                 & $past(learn_mirror_mask_ff)) == $past(learn_mirror_mask_ff))
    else $error("learn mirror ports not added");
  event_set_a: assert property (1'b1 |=> (sticky_event_flags_ff & $past(event_in)) == $past(event_in))
    else $error("event flag not set");
  event_hold_a: assert property (!(reg_req.wr && (reg_req.addr == amp_pkg::OFS_EVENTS))
                                 |=> (sticky_event_flags_ff & $past(sticky_event_flags_ff))
                                 == $past(sticky_event_flags_ff))
    else $error("event flag lost");
  self_kill_a: assert property (frame_in.valid && cpu_self_kill_enable_ff && (frame_in.src_port == amp_pkg::CPU_PORT)
                                |=> !frame_out.forward_port_mask[amp_pkg::CPU_PORT])
    else $error("cpu port not removed");
  port_move_a: assert property (move_valid && port_ok(move_port) |=> port_move_status_ff[$past(move_port)])
    else $error("port move not recorded");
  discard_cnt_a: assert property (learn_fail && !reg_req.wr
                                  |=> learn_discard_counter_ff == $past(learn_discard_counter_ff) + 1'b1)
    else $error("learn discard not counted");
  qos_index_a: assert property (rx_frame_s |=> frame_out.qos_pol_idx
                                == amp_pkg::POOL_QOS_BASE + amp_pkg::POOL_QOS_STRIDE * $past(frame_in.src_port)
                                + $past(frame_in.qos))
    else $error("qos policer index wrong");
  rule_index_a: assert property (frame_out.rule_pol_valid |-> frame_out.rule_pol_idx[7:6] == 2'h2)
    else $error("rule policer out of range");

endmodule // amp_analyzer

// ===== verilog/amp_pkg.sv
// Constants, register map and carrier types for the analyzer mirror, sample and policer-map block
package amp_pkg;
  localparam int NUM_PORTS = 12;
  localparam int PORT_W = 4;
  localparam logic [3:0] CPU_PORT = 4'hB;
  localparam int QOS_W = 3;
  localparam int NUM_QOS = 8;
  localparam int PROB_W = 12;
  localparam int VID_W = 12;
  localparam int NUM_VID = 4096;
  localparam int POL_W = 8;
  localparam int RULE_IDX_W = 6;
  localparam int QUEUE_W = 3;
  localparam int NUM_CPU_QUEUE_SET = 8;
  localparam int NUM_EVENTS = 23;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W = 32;
  localparam int LFSR_W = 24;
  localparam logic [23:0] LFSR_SEED = 24'h000001;
  localparam logic [23:0] LFSR_TAPS = 24'hE10000;
  // Policer pool layout
  localparam logic [7:0] POOL_PORT_BASE = 8'h00;
  localparam logic [7:0] POOL_QOS_BASE = 8'h20;
  localparam logic [7:0] POOL_QOS_STRIDE = 8'h08;
  localparam logic [7:0] POOL_RULE_BASE = 8'h80;
  // Register offsets (word addresses)
  localparam logic [7:0] OFS_SAMPLER = 8'h00;
  localparam logic [7:0] OFS_PORT_POLICER_ENABLES = 8'h10;
  localparam logic [7:0] OFS_MIRROR_CTRL = 8'h20;
  localparam logic [7:0] OFS_LEARN_MIRROR = 8'h21;
  localparam logic [7:0] OFS_EGRESS_MIRROR = 8'h22;
  localparam logic [7:0] OFS_MIRROR_PORTS = 8'h23;
  localparam logic [7:0] OFS_INGRESS_MIRROR = 8'h24;
  localparam logic [7:0] OFS_CPU_QUEUES = 8'h25;
  localparam logic [7:0] OFS_VLAN_INDEX = 8'h26;
  localparam logic [7:0] OFS_VID_MIRROR_FLAG = 8'h27;
  localparam logic [7:0] OFS_PORT_MOVE = 8'h28;
  localparam logic [7:0] OFS_EVENTS = 8'h29;
  localparam logic [7:0] OFS_LEARN_DISCARD = 8'h2A;
  // Field positions
  localparam int SMP_CFG_W = 14;
  localparam int SMP_RX_BIT = 12;
  localparam int SMP_TX_BIT = 13;
  localparam int PORT_POLICER_ENABLES_W = 11;
  localparam int POL_PORT_BIT = 0;
  localparam int POL_QOS_LSB = 1;
  localparam int POL_ORDER_LSB = 9;
  localparam int CTRL_CPU_MIRROR_BIT = 0;
  localparam int CTRL_KILL_BIT = 1;
  localparam int CPU_QUEUE_SET_SAMPLE_LSB = 0;
  localparam int MIRROR_CPU_QUEUE_LSB = 3;
  localparam logic [31:0] CFG_RESET = 32'h00000000;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } amp_reg_req_type;

  typedef struct packed {
    logic valid;
    logic [PORT_W-1:0] src_port;
    logic [QOS_W-1:0] qos;
    logic [VID_W-1:0] vid;
    logic learn_frame;
    logic learn_enabled;
    logic [NUM_PORTS-1:0] forward_port_mask;
    logic [NUM_CPU_QUEUE_SET-1:0] cpu_queue_set;
    logic rule_hit;
    logic rule_action_mirror;
    logic rule_police_enable;
    logic [RULE_IDX_W-1:0] rule_policer_index;
  } amp_frame_in_type;

  typedef struct packed {
    logic valid;
    logic [NUM_PORTS-1:0] forward_port_mask;
    logic [NUM_CPU_QUEUE_SET-1:0] cpu_queue_set;
    logic mirrored;
    logic sampled;
    logic port_pol_valid;
    logic [POL_W-1:0] port_pol_idx;
    logic qos_pol_valid;
    logic [POL_W-1:0] qos_pol_idx;
    logic rule_pol_valid;
    logic [POL_W-1:0] rule_pol_idx;
    logic [1:0] pol_order;
  } amp_frame_out_type;
endpackage

// ===== bench/amp_classifier_model.sv
// Upstream classifier model presenting one frame per request as a one-cycle pulse
`timescale 1ns/10ps
module amp_classifier_model
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic go,
  input wire amp_pkg::amp_frame_in_type nxt_frame,
  output amp_pkg::amp_frame_in_type frame_in
);
  // Idle payload toggles every cycle so stale fields never pass for a frame
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
      frame_in <= '0;
    else if (go)
      frame_in <= nxt_frame;
    else
      frame_in <= {1'b0, ~frame_in[$bits(frame_in)-2:0]};
  end
endmodule // amp_classifier_model

// ===== bench/amp_analyzer_tb_top.sv
// Self-checking bench for the analyzer mirror, sample and policer-map block
`timescale 1ns/10ps
module amp_analyzer_tb_top;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic go = 1'b0;
  logic tx_valid = 1'b0;
  logic move_valid = 1'b0;
  logic learn_fail = 1'b0;
  logic tx_sample;
  logic [3:0] tx_port = 4'h2;
  logic [3:0] move_port = 4'h0;
  logic [22:0] event_in = '0;
  logic [31:0] reg_rdata;
  amp_pkg::amp_reg_req_type reg_req = '0;
  amp_pkg::amp_frame_in_type frame_in;
  amp_pkg::amp_frame_in_type nxt_frame = '0;
  amp_pkg::amp_frame_out_type frame_out;
  int failures = 0;
  int cmp_count = 0;
  int hits;

  amp_classifier_model amp_classifier_model_inst (.clk_sys(clk_sys), .reset_n(reset_n), .go(go),
    .nxt_frame(nxt_frame), .frame_in(frame_in));
  amp_analyzer amp_analyzer_inst (.clk_sys(clk_sys), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .frame_in(frame_in), .frame_out(frame_out), .tx_valid(tx_valid), .tx_port(tx_port), .tx_sample(tx_sample),
    .move_valid(move_valid), .move_port(move_port), .event_in(event_in), .learn_fail(learn_fail));

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  task automatic final_report;
    if (failures == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Register bus cycles: one-cycle strobes, read data in the following cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_sys);
    reg_req <= '0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk_sys);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk_sys);
    reg_req <= '0;
    #1;
    chk(reg_rdata, exp);
  endtask

  function automatic amp_pkg::amp_frame_in_type mkf(input logic [3:0] p, input logic [11:0] fwd);
    mkf = '0;
    mkf.valid = 1'b1;
    mkf.src_port = p;
    mkf.vid = 12'h008;
    mkf.forward_port_mask = fwd;
  endfunction

  // One frame through the model; decision must appear exactly one cycle after it
  task automatic send(input amp_pkg::amp_frame_in_type f);
    @(posedge clk_sys);
    nxt_frame <= f;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk(frame_out.valid, 1'b1);
  endtask

  task automatic mir(input amp_pkg::amp_frame_in_type f, input logic [11:0] fwd, input logic [7:0] q, input logic m);
    send(f);
    chk({frame_out.forward_port_mask, frame_out.cpu_queue_set, frame_out.mirrored}, {fwd, q, m});
  endtask

  task automatic t_police;
    amp_pkg::amp_frame_in_type f;
    rd(8'h10, 32'h0);
    f = mkf(4'h3, 12'h001);
    f.qos = 3'h5;
    f.rule_hit = 1'b1;
    f.rule_police_enable = 1'b1;
    f.rule_policer_index = 6'h3F;
    send(f);
    chk({frame_out.port_pol_valid, frame_out.qos_pol_valid}, 2'h0);
    wr(8'h13, 32'h441);
    send(f);
    chk({frame_out.port_pol_valid, frame_out.port_pol_idx}, 9'h103);
    chk({frame_out.qos_pol_valid, frame_out.qos_pol_idx}, 9'h13D);
    chk({frame_out.rule_pol_valid, frame_out.rule_pol_idx, frame_out.pol_order}, 11'h6FE);
    f.qos = 3'h4;
    f.rule_police_enable = 1'b0;
    f.rule_policer_index = 6'h00;
    send(f);
    chk({frame_out.qos_pol_valid, frame_out.qos_pol_idx, frame_out.rule_pol_valid}, 10'h078);
  endtask

  task automatic t_mirror;
    amp_pkg::amp_frame_in_type f;
    f = mkf(4'h1, 12'h004);
    wr(8'h26, 32'h8);
    wr(8'h27, 32'h0);
    wr(8'h26, 32'h7);
    wr(8'h27, 32'h1);
    wr(8'h23, 32'h801);
    wr(8'h25, 32'h2A);
    mir(f, 12'h004, 8'h00, 1'b0);
    wr(8'h24, 32'h002);
    mir(f, 12'h805, 8'h20, 1'b1);
    wr(8'h24, 32'h0);
    wr(8'h22, 32'h004);
    mir(f, 12'h805, 8'h20, 1'b1);
    wr(8'h22, 32'h0);
    f.vid = 12'h007;
    mir(f, 12'h805, 8'h20, 1'b1);
    f = mkf(4'h1, 12'h004);
    f.rule_hit = 1'b1;
    f.rule_action_mirror = 1'b1;
    mir(f, 12'h805, 8'h20, 1'b1);
    wr(8'h21, 32'h010);
    f = mkf(4'h1, 12'h004);
    f.learn_frame = 1'b1;
    mir(f, 12'h805, 8'h20, 1'b1);
    f.learn_enabled = 1'b1;
    f.vid = 12'h007;
    wr(8'h24, 32'h002);
    mir(f, 12'h815, 8'h20, 1'b1);
    wr(8'h20, 32'h1);
    mir(mkf(4'h4, 12'h800), 12'h801, 8'h20, 1'b1);
    wr(8'h20, 32'h2);
    mir(mkf(4'hB, 12'h804), 12'h004, 8'h00, 1'b0);
    wr(8'h20, 32'h0);
  endtask

  // Counts sampled candidates out of 32 on port 2, received or transmitted
  task automatic samp(input logic [31:0] cfg, input logic tx, input int lo, input int hi);
    wr(8'h02, cfg);
    hits = 0;
    repeat (32)
    begin
      if (tx)
      begin
        @(posedge clk_sys);
        tx_valid <= 1'b1;
        @(posedge clk_sys);
        tx_valid <= 1'b0;
        #1;
        hits += int'(tx_sample === 1'b1);
      end
      else
      begin
        send(mkf(4'h2, 12'h001));
        hits += int'(frame_out.sampled === 1'b1);
        if (frame_out.sampled === 1'b1)
          chk({frame_out.forward_port_mask, frame_out.cpu_queue_set}, {12'h801, 8'h04});
      end
    end
    chk(hits >= lo && hits <= hi, 1'b1);
  endtask

  task automatic t_monitor;
    rd(8'h28, 32'h0);
    @(posedge clk_sys);
    move_valid <= 1'b1;
    move_port <= 4'h5;
    event_in <= 23'h400001;
    learn_fail <= 1'b1;
    @(posedge clk_sys);
    move_valid <= 1'b0;
    event_in <= '0;
    repeat (2) @(posedge clk_sys);
    learn_fail <= 1'b0;
    rd(8'h28, 32'h020);
    wr(8'h28, 32'h020);
    rd(8'h28, 32'h0);
    rd(8'h29, 32'h400001);
    wr(8'h29, 32'h1);
    rd(8'h29, 32'h400000);
    rd(8'h2A, 32'h3);
    wr(8'h2A, 32'h0);
    rd(8'h2A, 32'h0);
    rd(8'hFF, 32'h0);
  endtask

  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_police();
    t_mirror();
    samp(32'h1000, 1'b0, 0, 0);
    samp(32'h1FFF, 1'b0, 30, 32);
    samp(32'h1800, 1'b0, 6, 26);
    samp(32'h2FFF, 1'b0, 0, 0);
    samp(32'h2FFF, 1'b1, 30, 32);
    samp(32'h1FFF, 1'b1, 0, 0);
    t_monitor();
    final_report();
  end

  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    failures++;
    final_report();
  end
endmodule // amp_analyzer_tb_top
